/* File: psm_pkg.sv */
// Package of constants and carriers for the power source and state manager
package psm_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned STARTUP_US    = 2500;
  localparam int unsigned STARTUP_CYC   = STARTUP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LDO_STEP_US   = 100;
  localparam int unsigned LDO_STEP_CYC  = LDO_STEP_US * (CLK_HZ / 1_000_000);

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_PCON      = 8'h00;
  localparam logic [7:0] ADDR_GPREG0    = 8'h04;
  localparam logic [7:0] ADDR_PDCFG     = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;
  localparam logic [7:0] ADDR_WAKE_EN   = 8'h20;
  localparam int unsigned NUM_GPREG     = 5;

  // Power control fields
  localparam int unsigned PCON_PM_SEL   = 0;
  localparam int unsigned PCON_SLEEP_F  = 1;
  localparam int unsigned PCON_DPD_F    = 2;
  localparam int unsigned PCON_AUTO_DIS = 3;
  localparam int unsigned PCON_BAT_OFF  = 4;
  localparam int unsigned PCON_LDO12_EN = 5;
  localparam int unsigned PCON_LDO16_EN = 6;
  localparam int unsigned PCON_DROP_EN  = 7;
  localparam logic [31:0] PCON_RST      = 32'h0000_0060;

  // Wake enable fields
  localparam int unsigned WEN_WAKE_PIN  = 0;
  localparam int unsigned WEN_RF        = 1;
  localparam logic [31:0] WEN_RST       = 32'h0000_0000;
  localparam logic [31:0] PDCFG_RST     = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    PSM_SRC_NONE,
    PSM_SRC_BAT,
    PSM_SRC_FIELD
  } psm_src_t;

  typedef struct packed {
    logic rtc;
    logic watchdog;
    logic wake_pin;
    logic rf;
    logic start_irq;
  } psm_wake_t;

  typedef struct packed {
    logic digital_regulator_en;
    logic analog_regulator_en;
    logic core_por;
    logic boot_ok;
  } psm_pwr_t;

endpackage

/* File: psm_gpreg.sv */
// Retained general-purpose register bank
`timescale 1ns/1ns
module psm_gpreg #(
  parameter int unsigned N = 5
) (
  // Clock
  input  wire logic                 sys_clk_i,
  // Write port
  input  wire logic                 wr_i,
  input  wire logic [2:0]           wr_idx_i,
  input  wire logic [31:0]          wr_data_i,
  // Read port
  input  wire logic [2:0]           rd_idx_i,
  output logic      [31:0]          rd_data_o
);

  logic [31:0] mem [N];

  // ************************************************************
  // Storage, no reset so contents survive deep power-down
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (wr_i && (32'(wr_idx_i) < N)) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= (32'(rd_idx_i) < N) ? mem[rd_idx_i] : 32'h0000_0000;
  end

endmodule

/* File: psm_top.sv */
// Power source selection, power state and start-up sequencing
// Function
// - Battery switch open until pin or field trigger
// - Battery above threshold wins, preferred
// - Low battery with field uses field supply
// - Immediate switchover both directions
// - Auto switch disable forces battery, comparator off
// - Reset pin rising edge closes battery switch
// - No field: may open battery switch off
// - Enabled drop detector flags low rail
// - State flags and regulator encoding per state
// - Sequencer enables digital then analog regulator
// - Core reset after regulator and oscillator ready
// - Boot waits for flash ready
// - Start-up completes in about 2.5 ms
// - Field-only start-up follows same sequence
// - Timer oscillator cannot be disabled
// - Deep-sleep wake event set
// - Deep power-down wake event set
// - Five retained general-purpose registers
// - Power control selects mode, flags, overrides
// - Power-down config gates analog peripherals
// - Regulators enabled independently
`timescale 1ns/1ns
module psm_top
  import psm_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = psm_pkg::STARTUP_CYC,
  parameter int unsigned PDCFG_W        = 8
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // AXI4-Lite write
  input  wire logic [7:0]                s_awaddr_i,
  input  wire logic                      s_awvalid_i,
  output logic                           s_awready_o,
  input  wire logic [31:0]               s_wdata_i,
  input  wire logic [3:0]                s_wstrb_i,
  input  wire logic                      s_wvalid_i,
  output logic                           s_wready_o,
  output logic [1:0]                     s_bresp_o,
  output logic                           s_bvalid_o,
  input  wire logic                      s_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]                s_araddr_i,
  input  wire logic                      s_arvalid_i,
  output logic                           s_arready_o,
  output logic [31:0]                    s_rdata_o,
  output logic [1:0]                     s_rresp_o,
  output logic                           s_rvalid_o,
  input  wire logic                      s_rready_i,
  // Supply comparators and pins
  input  wire logic                      battery_ok_i,
  input  wire logic                      field_supply_i,
  input  wire logic                      reset_pin_low_i,
  input  wire logic                      rail_low_i,
  input  wire logic                      system_oscillator_ok_i,
  input  wire logic                      flash_ready_i,
  input  wire psm_pkg::psm_wake_t        wake_i,
  input  wire logic                      cpu_sleep_req_i,
  // Power outputs
  output logic                           battery_switch_o,
  output logic                           field_switch_o,
  output logic                           comparator_en_o,
  output psm_pkg::psm_pwr_t              pwr_o,
  output logic                           deep_powerdown_flag_o,
  output logic                           sleep_flag_o,
  output logic                           supply_drop_detector_o,
  output logic [PDCFG_W-1:0]             analog_pd_o
);
  import psm_pkg::*;

  typedef enum {
    ST_OFF, ST_LDO12, ST_LDO16, ST_WAIT, ST_ACTIVE, ST_SLEEP, ST_DPD
  } psm_state_t;

  psm_state_t  state;
  logic [31:0] pcon;
  logic [31:0] wake_en;
  logic [31:0] pdcfg;
  logic [1:0]  bat_sync;
  logic [1:0]  fld_sync;
  logic [1:0]  rst_sync;
  logic        rst_prev;
  logic [31:0] seq_cnt;
  logic        bat_closed;
  logic        por_done;
  logic        bat_q;
  logic        fld_q;
  logic        rst_rise;
  logic        any_wake_ds;
  logic        any_wake_dpd;
  // Bus
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        do_wr;
  logic        wr_ok;
  logic        rd_pend;
  logic [7:0]  ar_addr;
  logic [31:0] gp_rdata;
  logic        gp_wr;
  logic [2:0]  gp_widx;
  logic [2:0]  gp_ridx;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bat_sync <= 2'h0;
      fld_sync <= 2'h0;
      rst_sync <= 2'h3;
      rst_prev <= 1'b1;
    end else begin
      bat_sync <= {bat_sync[0], battery_ok_i};
      fld_sync <= {fld_sync[0], field_supply_i};
      rst_sync <= {rst_sync[0], reset_pin_low_i};
      rst_prev <= rst_sync[1];
    end
  end

  assign bat_q    = bat_sync[1];
  assign fld_q    = fld_sync[1];
  assign rst_rise = rst_sync[1] & ~rst_prev;

  // ************************************************************
  // Battery switch and source selection
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bat_closed <= 1'b0;
    end else if (rst_rise) begin
      bat_closed <= 1'b1;
    end else if (fld_q && !bat_closed) begin
      bat_closed <= 1'b1;
    end else if (pcon[PCON_BAT_OFF] && !fld_q) begin
      bat_closed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      battery_switch_o <= 1'b0;
      field_switch_o   <= 1'b0;
      comparator_en_o  <= 1'b1;
    end else begin
      comparator_en_o <= ~pcon[PCON_AUTO_DIS];
      if (pcon[PCON_AUTO_DIS]) begin
        battery_switch_o <= bat_closed;
        field_switch_o   <= 1'b0;
      end else begin
        battery_switch_o <= bat_closed & bat_q;
        field_switch_o   <= fld_q & ~(bat_closed & bat_q);
      end
    end
  end

  // ************************************************************
  // Power state machine
  // ************************************************************
  assign any_wake_ds  = rst_rise | wake_i.rtc | wake_i.watchdog
                        | wake_i.wake_pin | wake_i.start_irq
                        | (wake_i.rf & wake_en[WEN_RF]);
  assign any_wake_dpd = rst_rise | wake_i.rtc
                        | (wake_i.wake_pin & wake_en[WEN_WAKE_PIN])
                        | (wake_i.rf & wake_en[WEN_RF]);

  // Timer oscillator has no disable control anywhere
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state   <= ST_OFF;
      seq_cnt <= 32'h0000_0000;
    end else begin
      seq_cnt <= seq_cnt + 32'h0000_0001;
      case (state)
        ST_OFF: begin
          seq_cnt <= 32'h0000_0000;
          if (battery_switch_o || field_switch_o) begin
            state <= ST_LDO12;
          end
        end
        ST_LDO12: begin
          if (seq_cnt >= LDO_STEP_CYC - 1) begin
            state <= ST_LDO16;
          end
        end
        ST_LDO16: begin
          if (seq_cnt >= 2 * LDO_STEP_CYC - 1) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (flash_ready_i && por_done
              && seq_cnt >= STARTUP_CYCLES - 1) begin
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!battery_switch_o && !field_switch_o) begin
            state <= ST_OFF;
          end else if (cpu_sleep_req_i && pcon[PCON_PM_SEL]) begin
            state <= ST_DPD;
          end else if (cpu_sleep_req_i) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (any_wake_ds) begin
            state <= ST_ACTIVE;
          end
        end
        ST_DPD: begin
          seq_cnt <= 32'h0000_0000;
          if (any_wake_dpd) begin
            state <= ST_LDO12;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || state == ST_OFF || state == ST_DPD) begin
      por_done <= 1'b0;
    end else if (pwr_o.digital_regulator_en && system_oscillator_ok_i) begin
      por_done <= 1'b1;
    end
  end

  // ************************************************************
  // Power outputs
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pwr_o                 <= '0;
      deep_powerdown_flag_o <= 1'b0;
      sleep_flag_o          <= 1'b0;
    end else begin
      pwr_o.digital_regulator_en <= (state != ST_OFF) && (state != ST_DPD)
                                    && pcon[PCON_LDO12_EN];
      pwr_o.analog_regulator_en  <= (state != ST_OFF) && (state != ST_DPD)
                                    && (state != ST_LDO12)
                                    && pcon[PCON_LDO16_EN];
      pwr_o.core_por  <= por_done;
      pwr_o.boot_ok   <= (state == ST_ACTIVE) || (state == ST_SLEEP);
      deep_powerdown_flag_o <= (state == ST_DPD);
      sleep_flag_o          <= (state == ST_SLEEP);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      supply_drop_detector_o <= 1'b0;
      analog_pd_o            <= '0;
    end else begin
      supply_drop_detector_o <= pcon[PCON_DROP_EN] & rail_low_i;
      analog_pd_o            <= pdcfg[PDCFG_W-1:0];
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  assign do_wr   = aw_held && w_held && !s_bvalid_o;
  assign wr_ok   = (aw_addr == ADDR_PCON) || (aw_addr == ADDR_PDCFG)
                   || (aw_addr == ADDR_WAKE_EN)
                   || ((aw_addr >= ADDR_GPREG0) && (aw_addr < ADDR_PDCFG));
  assign gp_wr   = do_wr && (aw_addr >= ADDR_GPREG0)
                   && (aw_addr < ADDR_PDCFG) && (s_wstrb_i != 4'h0);
  assign gp_widx = 3'((aw_addr - ADDR_GPREG0) >> 2);
  assign gp_ridx = 3'((s_araddr_i - ADDR_GPREG0) >> 2);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr     <= 8'h00;
      w_data      <= 32'h0000_0000;
      s_awready_o <= 1'b1;
      s_wready_o  <= 1'b1;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= RESP_OKAY;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held     <= 1'b1;
        aw_addr     <= {s_awaddr_i[7:2], 2'b00};
        s_awready_o <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held     <= 1'b1;
        w_data     <= s_wdata_i;
        s_wready_o <= 1'b0;
      end
      if (do_wr) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_held    <= 1'b0;
        w_held     <= 1'b0;
      end
      if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o  <= 1'b0;
        s_awready_o <= 1'b1;
        s_wready_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pcon    <= PCON_RST;
      wake_en <= WEN_RST;
      pdcfg   <= PDCFG_RST;
    end else if (do_wr) begin
      case (aw_addr)
        ADDR_PCON:    pcon    <= w_data;
        ADDR_WAKE_EN: wake_en <= w_data;
        ADDR_PDCFG:   pdcfg   <= w_data;
        default:      pcon    <= pcon;
      endcase
    end
  end

  psm_gpreg #(
    .N (NUM_GPREG)
  ) u_gpreg (
    .sys_clk_i (sys_clk_i),
    .wr_i      (gp_wr),
    .wr_idx_i  (gp_widx),
    .wr_data_i (w_data),
    .rd_idx_i  (gp_ridx),
    .rd_data_o (gp_rdata)
  );

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_pend     <= 1'b0;
      ar_addr     <= 8'h00;
      s_arready_o <= 1'b1;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0000_0000;
      s_rresp_o   <= RESP_OKAY;
    end else begin
      if (s_arvalid_i && s_arready_o) begin
        rd_pend     <= 1'b1;
        ar_addr     <= {s_araddr_i[7:2], 2'b00};
        s_arready_o <= 1'b0;
      end
      if (rd_pend) begin
        rd_pend    <= 1'b0;
        s_rvalid_o <= 1'b1;
        s_rresp_o  <= RESP_OKAY;
        case (ar_addr)
          ADDR_PCON: begin
            s_rdata_o <= pcon;
            s_rdata_o[PCON_SLEEP_F] <= sleep_flag_o;
            s_rdata_o[PCON_DPD_F]   <= deep_powerdown_flag_o;
          end
          ADDR_WAKE_EN: s_rdata_o <= wake_en;
          ADDR_PDCFG:   s_rdata_o <= pdcfg;
          ADDR_STATUS:  s_rdata_o <= {24'h000000, supply_drop_detector_o,
                                      pwr_o, battery_switch_o,
                                      field_switch_o, fld_q};
          default: begin
            if ((ar_addr >= ADDR_GPREG0) && (ar_addr < ADDR_PDCFG)) begin
              s_rdata_o <= gp_rdata;
            end else begin
              s_rdata_o <= 32'h0000_0000;
              s_rresp_o <= RESP_SLVERR;
            end
          end
        endcase
      end
      if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o  <= 1'b0;
        s_arready_o <= 1'b1;
      end
    end
  end

endmodule

/* File: psm_props.sv */
// Property checker for the power source and state manager
`timescale 1ns/1ns
module psm_props
  import psm_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               srst_i,
  // Observed ports
  input  wire logic               battery_switch_o,
  input  wire logic               field_switch_o,
  input  wire logic               comparator_en_o,
  input  wire psm_pkg::psm_pwr_t  pwr_o,
  input  wire logic               deep_powerdown_flag_o,
  input  wire logic               sleep_flag_o,
  input  wire logic               supply_drop_detector_o,
  input  wire logic               rail_low_i,
  input  wire logic               system_oscillator_ok_i,
  input  wire logic               flash_ready_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_one_source: assert property (
    !(battery_switch_o && field_switch_o))
    else $error("both supply switches closed");
  a_flags_apart: assert property (
    !(deep_powerdown_flag_o && sleep_flag_o))
    else $error("sleep and power-down flags together");
  a_dpd_regs_off: assert property (
    deep_powerdown_flag_o |-> !pwr_o.digital_regulator_en
      && !pwr_o.analog_regulator_en)
    else $error("regulator on in power-down");
  a_sleep_regs_on: assert property (
    sleep_flag_o |-> pwr_o.digital_regulator_en
      && pwr_o.analog_regulator_en)
    else $error("regulator off in sleep");
  a_digital_first: assert property (
    $rose(pwr_o.digital_regulator_en) |-> !pwr_o.analog_regulator_en)
    else $error("analog regulator before digital");
  a_analog_after: assert property (
    $rose(pwr_o.analog_regulator_en)
      |-> $past(pwr_o.digital_regulator_en, 8))
    else $error("analog regulator too early");
  a_por_ready: assert property (
    $rose(pwr_o.core_por) |-> pwr_o.digital_regulator_en
      && $past(system_oscillator_ok_i))
    else $error("core reset released too early");
  a_boot_flash: assert property (
    $rose(pwr_o.boot_ok) |-> pwr_o.core_por && $past(flash_ready_i))
    else $error("boot without flash ready");
  a_drop_cause: assert property (
    supply_drop_detector_o |-> $past(rail_low_i))
    else $error("drop flag without low rail");
  a_forced_bat: assert property (
    !comparator_en_o |-> !field_switch_o)
    else $error("field selected while auto switch off");
endmodule

/* File: psm_partner.sv */
// Model of the external battery, reset pin, field and wake pin
`timescale 1ns/1ns
module psm_partner #(
  parameter int unsigned WAKE_CYC = 2000
) (
  // Clock
  input  wire logic  sys_clk_i,
  // Commands from the bench
  input  wire logic  bat_on_i,
  input  wire logic  fld_on_i,
  input  wire logic  press_i,
  input  wire logic  wake_req_i,
  // Levels seen by the device
  output logic       battery_ok_o,
  output logic       field_supply_o,
  output logic       reset_pin_low_o,
  output logic       wake_pin_o
);
  logic [3:0]  hold = 4'h0;
  logic [11:0] wcnt = 12'h000;

  // Supplies follow the bench
  always_ff @(posedge sys_clk_i) begin
    battery_ok_o   <= bat_on_i;
    field_supply_o <= fld_on_i;
  end

  // Pin held low, then back to its pull-up
  always_ff @(posedge sys_clk_i) begin
    if (press_i) begin
      hold <= 4'hf;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
  assign reset_pin_low_o = (hold == 4'h0);

  // Wake pin low for the full minimum time
  always_ff @(posedge sys_clk_i) begin
    if (wake_req_i) begin
      wcnt <= 12'(WAKE_CYC);
    end else if (wcnt != 12'h000) begin
      wcnt <= wcnt - 12'h001;
    end
  end
  assign wake_pin_o = (wcnt == 12'h000);
endmodule

/* File: tb_psm_top.sv */
// Self-checking bench for the power source and state manager
`timescale 1ns/1ns
module tb_psm_top;
  import psm_pkg::*;
  localparam int unsigned SC = 4500;
  logic        sys_clk_i, srst_i, s_awvalid_i, s_awready_o, s_wvalid_i;
  logic [7:0]  s_awaddr_i, s_araddr_i, analog_pd_o;
  logic [31:0] s_wdata_i, s_rdata_o;
  logic [3:0]  s_wstrb_i;
  logic [1:0]  s_bresp_o, s_rresp_o;
  logic        s_wready_o, s_bvalid_o, s_bready_i, s_arvalid_i;
  logic        s_arready_o, s_rvalid_o, s_rready_i, battery_ok_i;
  logic        field_supply_i, reset_pin_low_i, rail_low_i, flash_ready_i;
  logic        system_oscillator_ok_i, cpu_sleep_req_i, battery_switch_o;
  logic        field_switch_o, comparator_en_o, deep_powerdown_flag_o;
  logic        sleep_flag_o, supply_drop_detector_o;
  logic        bat_on, fld_on, press, wreq, wpin;
  logic [4:0]  wk;
  psm_wake_t   wake_i;
  psm_pwr_t    pwr_o;
  int          mismatches, num_checks, n;

  assign wake_i = psm_wake_t'(wk | {2'b00, ~wpin, 2'b00});

  psm_top #(.STARTUP_CYCLES(SC)) uut (
    .sys_clk_i, .srst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
    .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o,
    .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
    .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .battery_ok_i,
    .field_supply_i, .reset_pin_low_i, .rail_low_i, .flash_ready_i,
    .system_oscillator_ok_i, .wake_i, .cpu_sleep_req_i, .battery_switch_o,
    .field_switch_o, .comparator_en_o, .pwr_o, .deep_powerdown_flag_o,
    .sleep_flag_o, .supply_drop_detector_o, .analog_pd_o);

  psm_partner ext (.sys_clk_i, .bat_on_i(bat_on), .fld_on_i(fld_on),
    .press_i(press), .wake_req_i(wreq), .battery_ok_o(battery_ok_i),
    .field_supply_o(field_supply_i), .reset_pin_low_o(reset_pin_low_i),
    .wake_pin_o(wpin));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic tick(int k = 1);
    repeat (k) @(posedge sys_clk_i);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic guard(int k, int lim);
    if (k > lim) begin
      chk("wait bound", 0, 1);
      conclude();
    end
  endtask

  function automatic logic [8:0] st();
    return {comparator_en_o, battery_switch_o, field_switch_o, pwr_o,
            deep_powerdown_flag_o, sleep_flag_o};
  endfunction

  function automatic logic [3:0] fl();
    return {pwr_o.digital_regulator_en, pwr_o.analog_regulator_en,
            deep_powerdown_flag_o, sleep_flag_o};
  endfunction

  function automatic logic sig(int s);
    case (s)
      0: return battery_switch_o;
      1: return field_switch_o;
      2: return pwr_o.digital_regulator_en;
      3: return pwr_o.analog_regulator_en;
      4: return pwr_o.boot_ok;
      5: return sleep_flag_o;
      default: return deep_powerdown_flag_o;
    endcase
  endfunction

  task automatic wait_on(int s, logic v, output int k);
    k = 0;
    while (sig(s) !== v) begin
      tick();
      k++;
      guard(k, 6000);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int k = 0;
    s_awaddr_i  <= a;
    s_wdata_i   <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i  <= 1'b1;
    s_bready_i  <= 1'b1;
    do begin
      tick();
      k++;
      guard(k, 50);
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
    end while (!s_bvalid_o);
    s_bready_i <= 1'b0;
    chk("bresp", er, s_bresp_o);
    tick();
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int k = 0;
    s_araddr_i  <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i  <= 1'b1;
    do begin
      tick();
      k++;
      guard(k, 50);
      if (s_arready_o) s_arvalid_i <= 1'b0;
    end while (!s_rvalid_o);
    s_rready_i <= 1'b0;
    chk("rresp", er, s_rresp_o);
    chk("rdata", ed, s_rdata_o);
    tick();
  endtask

  task automatic pulse_req(int s);
    if (s == 0) cpu_sleep_req_i <= 1'b1;
    else if (s == 1) press <= 1'b1;
    else wreq <= 1'b1;
    tick();
    {cpu_sleep_req_i, press, wreq} <= 3'b000;
  endtask

  initial begin
    {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
    {s_awaddr_i, s_araddr_i, s_wdata_i, wk} = '0;
    {rail_low_i, flash_ready_i, cpu_sleep_req_i, fld_on, press, wreq} = '0;
    {system_oscillator_ok_i, bat_on, srst_i} = 3'b111;
    s_wstrb_i = 4'hf;
    {mismatches, num_checks} = '0;
    tick(5);
    srst_i <= 1'b0;
    tick(100);
    chk("idle", 9'h100, st());
    rd(ADDR_PCON, PCON_RST, RESP_OKAY);
    pulse_req(1);
    wait_on(0, 1'b1, n);
    wait_on(2, 1'b1, n);
    chk("analog first", 0, sig(3));
    wait_on(3, 1'b1, n);
    chk("ldo gap", 1, 32'(n >= LDO_STEP_CYC - 3 && n <= LDO_STEP_CYC + 3));
    tick(SC);
    chk("no boot", 0, sig(4));
    flash_ready_i <= 1'b1;
    wait_on(4, 1'b1, n);
    guard(n, 8);
    chk("active", 9'h1bc, st());
    rd(ADDR_STATUS, 32'h0000_007c, RESP_OKAY);
    for (int i = 0; i < NUM_GPREG; i++) begin
      wr(ADDR_GPREG0 + 8'(4 * i), 32'hc0de_0000 + i, RESP_OKAY);
    end
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(ADDR_PDCFG, 32'h0000_00a5, RESP_OKAY);
    tick(2);
    chk("pd out", 8'ha5, analog_pd_o);
    wr(ADDR_PCON, 32'h0000_00e0, RESP_OKAY);
    rail_low_i <= 1'b1;
    tick(3);
    chk("drop on", 1, supply_drop_detector_o);
    wr(ADDR_PCON, PCON_RST, RESP_OKAY);
    tick(3);
    chk("drop off", 0, supply_drop_detector_o);
    wr(ADDR_PCON, 32'h0000_0020, RESP_OKAY);
    chk("analog off", 4'b1000, fl());
    wr(ADDR_PCON, PCON_RST, RESP_OKAY);
    rail_low_i <= 1'b0;
    fld_on <= 1'b1;
    tick(6);
    chk("both", 9'h1bc, st());
    bat_on <= 1'b0;
    tick(6);
    chk("to field", 2'b01, {battery_switch_o, field_switch_o});
    bat_on <= 1'b1;
    tick(6);
    chk("to battery", 2'b10, {battery_switch_o, field_switch_o});
    wr(ADDR_PCON, 32'h0000_0068, RESP_OKAY);
    bat_on <= 1'b0;
    tick(6);
    chk("forced", 3'b010, st() >> 6);
    wr(ADDR_PCON, PCON_RST, RESP_OKAY);
    {bat_on, fld_on} <= 2'b10;
    tick(6);
    wr(ADDR_WAKE_EN, 32'h0000_0003, RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      pulse_req(0);
      wait_on(5, 1'b1, n);
      chk("sleep", 4'b1101, fl());
      wk <= 5'(1 << k);
      wait_on(5, 1'b0, n);
      wk <= '0;
      tick(4);
    end
    wr(ADDR_PCON, 32'h0000_0061, RESP_OKAY);
    pulse_req(0);
    wait_on(6, 1'b1, n);
    chk("dpd", 4'b0010, fl());
    wk <= 5'b01001;
    tick(20);
    chk("dpd hold", 1, deep_powerdown_flag_o);
    wk <= '0;
    pulse_req(2);
    wait_on(6, 1'b0, n);
    wait_on(2, 1'b1, n);
    wait_on(4, 1'b1, n);
    chk("boot time", 1, 32'(n >= SC - 12 && n <= SC + 12));
    for (int i = 0; i < NUM_GPREG; i++) begin
      rd(ADDR_GPREG0 + 8'(4 * i), 32'hc0de_0000 + i, RESP_OKAY);
    end
    wr(ADDR_PCON, 32'h0000_0070, RESP_OKAY);
    wait_on(0, 1'b0, n);
    bat_on <= 1'b0;
    tick(10);
    chk("off", 9'h100, st());
    fld_on <= 1'b1;
    wait_on(1, 1'b1, n);
    wait_on(4, 1'b1, n);
    chk("field active", 9'h17c, st());
    conclude();
  end
endmodule

bind psm_top psm_props u_props (
  .sys_clk_i, .srst_i, .battery_switch_o, .field_switch_o,
  .comparator_en_o, .pwr_o, .deep_powerdown_flag_o, .sleep_flag_o,
  .supply_drop_detector_o, .rail_low_i, .system_oscillator_ok_i,
  .flash_ready_i);
